// file: tps_pkg.sv
package tps_pkg;

  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 6;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL  = 6'h05;
  localparam logic [IDX_W-1:0] IDX_CPU_STATUS     = 6'h06;
  localparam logic [IDX_W-1:0] IDX_INT_STATUS_EN  = 6'h07;
  localparam logic [IDX_W-1:0] IDX_COUNT_LOW      = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_COUNT_HIGH     = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_EVENT_STATUS   = 6'h10;
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK     = 6'h11;

  // timer_control fields
  localparam int CTL_INT_EDGE_BIT = 7;
  localparam int CTL_EDGE_BIT     = 6;
  localparam int CTL_SRC_BIT      = 5;
  localparam int CTL_PS_HI        = 4;
  localparam int CTL_PS_LO        = 1;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // cpu_status and interrupt_status_enable fields
  localparam int CPU_GLOBAL_IRQ_DISABLE_BIT      = 4;
  localparam logic CPU_GLOBAL_IRQ_DISABLE_RESET  = 1'b1;
  localparam int INT_OVF_FLAG_BIT    = 5;
  localparam int INT_OVF_EN_BIT      = 1;
  localparam logic [7:0] INT_RESET   = 8'h00;

  // Event status / mask layout
  localparam int EVT_OVERFLOW = 0;
  localparam int EVT_TICK     = 1;
  localparam int EVT_N        = 2;
  localparam logic [EVT_N-1:0] EVT_RESET = 2'h0;

  // Counter and prescaler
  localparam logic [15:0] COUNT_POR_VALUE = 16'h0000;
  localparam int PS_W = 9;
  localparam logic [3:0] PS_TAP_MAX = 4'h8;
  localparam logic [1:0] INHIBIT_SPAN = 2'h2;

  // Instruction cycle is four oscillator periods
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 10;
  localparam int SYNC_MIN_OSC  = 3;
  localparam int SYNC_MAX_OSC  = 7;
  localparam int SYNC_MIN_CYC  = (SYNC_MIN_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_MAX_CYC  = (SYNC_MAX_OSC * OSC_PERIOD_NS) / CLK_PERIOD_NS;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } tps_bus_state_t;

endpackage

// file: tps_timer16.sv
// What this block does
// - External pin events pass the prescaler before being synchronised.
// - Prescaler output sampled twice per instruction cycle; any transition makes a count.
// - Counter moves 3 to 7 oscillator periods after the external edge.
// - The 16-bit count is reached one byte at a time, low and high.
// - Writing a count byte stops that byte counting until the second instruction boundary after the write.
// - Any write to either count byte clears the prescaler.
// - Prescale ratio can be changed any time without stopping the timer.
// - Count is cleared to 0000 at power-on and kept across the other resets.
// - Count wraps FFFF to 0000 setting the overflow flag; vectoring clears it.
// - Source select picks instruction clock, else pin on chosen edge.
// - Prescale codes 0 to 7 divide by 1 to 128; top bit set divides 256.
module tps_timer16
  import tps_pkg::*;
(
  // Clock and resets
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              other_reset_in,
  // Count pin and CPU side
  input  wire logic              external_count_pin_in,
  input  wire logic              vector_ack_in,
  output logic                   overflow_request_out,
  output logic                   global_irq_disable_out,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address_in,
  input  wire logic              read_in,
  input  wire logic              write_in,
  input  wire logic [DATA_W-1:0] writedata_in,
  input  wire logic [3:0]        byteenable_in,
  output logic [DATA_W-1:0]      readdata_out,
  output logic                   waitrequest_out,
  // Interrupt
  output logic                   irq_out
);

  localparam int LAT_MIN = SYNC_MIN_CYC - 1;
  localparam int LAT_MAX = SYNC_MAX_CYC - 1;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
  endfunction

  function automatic logic [3:0] ps_tap(input logic [3:0] sel);
    return sel[3] ? PS_TAP_MAX : {1'b0, sel[2:0]};
  endfunction

  tps_bus_state_t bus_state;
  tps_bus_state_t next_bus_state;

  logic [1:0]       phase;
  logic             int_edge_store;
  logic             edge_select;
  logic             source_select;
  logic [3:0]       prescale_select;
  logic             overflow_flag;
  logic             overflow_irq_enable;
  logic [EVT_N-1:0] evt_status;
  logic [EVT_N-1:0] evt_mask;
  logic [EVT_N-1:0] next_evt_status;
  logic [7:0]       count_low;
  logic [7:0]       count_high;
  logic [1:0]       inhibit_low;
  logic [1:0]       inhibit_high;
  logic             pin_q;
  logic [PS_W-1:0]  ps_cnt;
  logic             ps_sample;
  logic             ps_sample_prev;

  // Phase and sample strobes
  wire inst_en   = (phase == PHASE_LAST);
  wire sample_en = phase[0];

  // Bus decode
  wire       bus_req    = read_in || write_in;
  wire       wr_go      = write_in && !waitrequest_out && byteenable_in[0];
  wire [7:0] wbyte      = writedata_in[7:0];
  wire       wr_ctl     = wr_go && reg_hit(address_in, IDX_TIMER_CONTROL);
  wire       wr_cpu     = wr_go && reg_hit(address_in, IDX_CPU_STATUS);
  wire       wr_int     = wr_go && reg_hit(address_in, IDX_INT_STATUS_EN);
  wire       wr_low     = wr_go && reg_hit(address_in, IDX_COUNT_LOW);
  wire       wr_high    = wr_go && reg_hit(address_in, IDX_COUNT_HIGH);
  wire       wr_evt     = wr_go && reg_hit(address_in, IDX_EVENT_STATUS);
  wire       wr_mask    = wr_go && reg_hit(address_in, IDX_EVENT_MASK);
  wire       wr_cnt_any = wr_low || wr_high;
  wire       ctrl_rst   = srst_in || other_reset_in;

  wire [7:0] ctl_rd = {int_edge_store, edge_select, source_select, prescale_select, 1'b0};
  wire [7:0] cpu_rd = {3'h0, global_irq_disable_out, 4'h0};
  wire [7:0] int_rd = {2'h0, overflow_flag, 3'h0, overflow_irq_enable, 1'b0};
  wire [7:0] rd_byte =
    reg_hit(address_in, IDX_TIMER_CONTROL) ? ctl_rd :
    reg_hit(address_in, IDX_CPU_STATUS)    ? cpu_rd :
    reg_hit(address_in, IDX_INT_STATUS_EN) ? int_rd :
    reg_hit(address_in, IDX_COUNT_LOW)     ? count_low :
    reg_hit(address_in, IDX_COUNT_HIGH)    ? count_high :
    reg_hit(address_in, IDX_EVENT_STATUS)  ? {6'h00, evt_status} :
    reg_hit(address_in, IDX_EVENT_MASK)    ? {6'h00, evt_mask} : 8'h00;

  // Count source: pin edge of chosen polarity or instruction clock
  wire pin_rise  = external_count_pin_in && !pin_q;
  wire pin_fall  = !external_count_pin_in && pin_q;
  wire src_event = source_select ? inst_en : (edge_select ? pin_rise : pin_fall);

  // Prescaler tap toggles once per ratio events; each toggle is one count
  wire [3:0] tap              = ps_tap(prescale_select);
  wire       prescaler_output = ps_cnt[tap];

  // Tick uses samples taken before the current edge, giving the sync delay
  wire count_tick = sample_en && (ps_sample ^ ps_sample_prev);
  wire low_inc    = count_tick && (inhibit_low == 2'h0);
  wire low_carry  = low_inc && (count_low == 8'hFF);
  wire high_inc   = low_carry && (inhibit_high == 2'h0);
  wire wrap       = high_inc && (count_high == 8'hFF);

  wire [EVT_N-1:0] evt_set = {count_tick, wrap};

  assign next_bus_state = (bus_state == BUS_IDLE && bus_req) ? BUS_ACK : BUS_IDLE;

  // One wait cycle per access; unmapped reads return zero, writes dropped
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bus_state       <= BUS_IDLE;
      waitrequest_out <= 1'b1;
      readdata_out    <= 32'h0000_0000;
    end else begin
      bus_state       <= next_bus_state;
      waitrequest_out <= (next_bus_state == BUS_IDLE);
      if (read_in && bus_state == BUS_IDLE) begin
        readdata_out <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Ratio and source change on the fly; counting never stops for it
  always_ff @(posedge clk_in) begin
    if (ctrl_rst) begin
      {int_edge_store, edge_select, source_select, prescale_select} <= CTL_RESET[7:1];
    end else if (wr_ctl) begin
      int_edge_store  <= wbyte[CTL_INT_EDGE_BIT];
      edge_select     <= wbyte[CTL_EDGE_BIT];
      source_select   <= wbyte[CTL_SRC_BIT];
      prescale_select <= wbyte[CTL_PS_HI:CTL_PS_LO];
    end
  end

  always_ff @(posedge clk_in) begin
    if (ctrl_rst) begin
      global_irq_disable_out <= CPU_GLOBAL_IRQ_DISABLE_RESET;
      overflow_irq_enable    <= INT_RESET[INT_OVF_EN_BIT];
      overflow_flag          <= INT_RESET[INT_OVF_FLAG_BIT];
      overflow_request_out   <= 1'b0;
    end else begin
      if (wr_cpu) begin
        global_irq_disable_out <= wbyte[CPU_GLOBAL_IRQ_DISABLE_BIT];
      end
      if (wr_int) begin
        overflow_irq_enable <= wbyte[INT_OVF_EN_BIT];
      end
      // Wrap beats a simultaneous vector clear or software write
      if (wrap) begin
        overflow_flag <= 1'b1;
      end else if (vector_ack_in) begin
        overflow_flag <= 1'b0;
      end else if (wr_int) begin
        overflow_flag <= wbyte[INT_OVF_FLAG_BIT];
      end
      overflow_request_out <= overflow_flag && overflow_irq_enable && !global_irq_disable_out;
    end
  end

  // Sticky events, write one to clear, set wins
  generate
    for (genvar i = 0; i < EVT_N; i++) begin : g_evt
      assign next_evt_status[i] = evt_set[i] || (evt_status[i] && !(wr_evt && wbyte[i]));
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (ctrl_rst) begin
      evt_status <= EVT_RESET;
      evt_mask   <= EVT_RESET;
      irq_out    <= 1'b0;
    end else begin
      evt_status <= next_evt_status;
      if (wr_mask) begin
        evt_mask <= wbyte[EVT_N-1:0];
      end
      irq_out <= |(evt_status & evt_mask);
    end
  end

  // Prescaler first, then the twice-per-cycle sampler
  always_ff @(posedge clk_in) begin
    if (srst_in || wr_cnt_any) begin
      ps_cnt <= '0;
    end else if (src_event) begin
      ps_cnt <= ps_cnt + 9'h001;
    end
  end

  // Samples are cleared with the prescaler so the clear is not seen as an edge
  always_ff @(posedge clk_in) begin
    pin_q <= srst_in ? 1'b0 : external_count_pin_in;
    if (srst_in || wr_cnt_any) begin
      ps_sample      <= 1'b0;
      ps_sample_prev <= 1'b0;
    end else if (sample_en) begin
      ps_sample      <= prescaler_output;
      ps_sample_prev <= ps_sample;
    end
  end

  // Count kept on master clear and watchdog reset; power-on gives a fixed value
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count_low  <= COUNT_POR_VALUE[7:0];
      count_high <= COUNT_POR_VALUE[15:8];
    end else begin
      if (wr_low) begin
        count_low <= wbyte;
      end else if (low_inc) begin
        count_low <= count_low + 8'h01;
      end
      if (wr_high) begin
        count_high <= wbyte;
      end else if (high_inc) begin
        count_high <= count_high + 8'h01;
      end
    end
  end

  // Inhibit ends at the second instruction boundary after the write
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      inhibit_low  <= 2'h0;
      inhibit_high <= 2'h0;
    end else begin
      if (wr_low) begin
        inhibit_low <= INHIBIT_SPAN;
      end else if (inst_en && inhibit_low != 2'h0) begin
        inhibit_low <= inhibit_low - 2'h1;
      end
      if (wr_high) begin
        inhibit_high <= INHIBIT_SPAN;
      end else if (inst_en && inhibit_high != 2'h0) begin
        inhibit_high <= inhibit_high - 2'h1;
      end
    end
  end

  chk_prescaler_clear: assert property (
    @(posedge clk_in) disable iff (srst_in)
    wr_cnt_any |=> (ps_cnt == '0) && !ps_sample && !ps_sample_prev)
    else $error("prescaler not cleared by count write");

  chk_low_write_hold: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (wr_low ##1 !wr_low [*3]) |-> (count_low == $past(writedata_in[7:0], 3)))
    else $error("low byte moved during write inhibit");

  chk_wrap_overflow: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (count_tick && inhibit_low == 2'h0 && inhibit_high == 2'h0 && !wr_cnt_any
     && count_low == 8'hFF && count_high == 8'hFF)
    |=> overflow_flag && count_low == 8'h00 && count_high == 8'h00 && evt_status[EVT_OVERFLOW])
    else $error("wrap did not give zero count and overflow flag");

  chk_vector_clear: assert property (
    @(posedge clk_in) disable iff (ctrl_rst)
    (vector_ack_in && !wrap) |=> !overflow_flag)
    else $error("overflow flag not cleared by vectoring");

  chk_tick_phase: assert property (
    @(posedge clk_in) disable iff (srst_in)
    $changed(count_low) && !$past(wr_low) |-> $past(sample_en))
    else $error("count changed outside a sample point");

  chk_two_samples: assert property (
    @(posedge clk_in) disable iff (srst_in)
    sample_en |=> !sample_en ##1 sample_en)
    else $error("sampler not running twice per instruction cycle");

  chk_ext_latency: assert property (
    @(posedge clk_in) disable iff (srst_in || wr_cnt_any || wr_ctl)
    (!source_select && src_event && prescale_select == 4'h0) |-> ##[LAT_MIN:LAT_MAX] count_tick)
    else $error("external edge not counted in time");

  chk_internal_source: assert property (
    @(posedge clk_in) disable iff (srst_in)
    source_select |-> (src_event == inst_en))
    else $error("internal source not the instruction clock");

  chk_top_ratio: assert property (
    @(posedge clk_in) disable iff (srst_in)
    prescale_select[3] |-> (prescaler_output == ps_cnt[PS_W-1]))
    else $error("top prescale code not dividing by 256");

  chk_bus_answer: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (bus_req && waitrequest_out) |=> !waitrequest_out ##1 waitrequest_out)
    else $error("bus access not answered after one wait cycle");

  chk_irq_level: assert property (
    @(posedge clk_in) disable iff (ctrl_rst)
    (|(evt_status & evt_mask)) |=> irq_out)
    else $error("unmasked event did not raise irq");

  chk_high_write_hold: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (wr_high ##1 !wr_high [*3]) |-> (count_high == $past(writedata_in[7:0], 3)))
    else $error("high byte moved during write inhibit");

  chk_count_kept: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (other_reset_in && !wr_cnt_any && !count_tick) |=> $stable(count_low) && $stable(count_high))
    else $error("count changed by a non power-on reset");

  chk_tick_advance: assert property (
    @(posedge clk_in) disable iff (srst_in)
    (count_tick && inhibit_low == 2'h0 && !wr_low) |=> (count_low == 8'($past(count_low) + 8'h01)))
    else $error("count did not advance on a prescaler pulse");

  chk_ovf_request: assert property (
    @(posedge clk_in) disable iff (ctrl_rst)
    (overflow_flag && overflow_irq_enable && !global_irq_disable_out) |=> overflow_request_out)
    else $error("overflow request not raised");

  cov_wrap: cover property (@(posedge clk_in) disable iff (srst_in) wrap);
  cov_ext_tick: cover property (@(posedge clk_in) disable iff (srst_in) !source_select && count_tick);
  cov_inhibited: cover property (@(posedge clk_in) disable iff (srst_in) count_tick && inhibit_low != 2'h0);
  cov_vector: cover property (@(posedge clk_in) disable iff (srst_in) overflow_flag ##1 vector_ack_in);

endmodule

// file: tps_pin_model.sv
module tps_pin_model (
  // Clock
  input  wire logic clk_in,
  // Count pin
  output logic      pin_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pin_out = 1'b0;

  // Each pulse holds each level for four clocks, so the twice-per-cycle
  // sampling can never miss an edge; the pin rests low between bursts
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_in);
      pin_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      pin_out <= 1'b0;
    end
    repeat (12) @(posedge clk_in);
  endtask
endmodule

// file: tps_timer16_test.sv
module tps_timer16_test;
  import tps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_in;
  logic              srst_in;
  logic              other_reset_in;
  logic              pin;
  logic              vector_ack_in;
  logic              overflow_request_out;
  logic              global_irq_disable_out;
  logic [ADDR_W-1:0] address_in;
  logic              read_in;
  logic              write_in;
  logic [DATA_W-1:0] writedata_in;
  logic [3:0]        byteenable_in;
  logic [DATA_W-1:0] readdata_out;
  logic              waitrequest_out;
  logic              irq_out;
  int                fails;
  int                total_checks;
  int                expq[$];
  logic [15:0]       v;
  logic [15:0]       r;
  logic [7:0]        a;
  logic [7:0]        b;
  logic [7:0]        d;
  logic [3:0]        code;

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  tps_timer16 tps_timer16_i (
    .clk_in(clk_in), .srst_in(srst_in), .other_reset_in(other_reset_in),
    .external_count_pin_in(pin), .vector_ack_in(vector_ack_in),
    .overflow_request_out(overflow_request_out), .global_irq_disable_out(global_irq_disable_out),
    .address_in(address_in), .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(byteenable_in), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .irq_out(irq_out)
  );

  tps_pin_model tps_pin_model_i (.clk_in(clk_in), .pin_out(pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // A read notes its expected value first; -1 means the caller judges it
  task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] wd,
                     input logic [3:0] be, input int exp, output logic [7:0] rd);
    if (!wr) expq.push_back(exp);
    @(posedge clk_in);
    address_in    <= {idx, 2'b00};
    read_in       <= !wr;
    write_in      <= wr;
    writedata_in  <= {24'h000000, wd};
    byteenable_in <= be;
    // Waits for the answer however long; only the watchdog ends a hung access
    do begin
      @(posedge clk_in);
    end while (waitrequest_out !== 1'b0);
    rd = readdata_out[7:0];
    read_in  <= 1'b0;
    write_in <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] x;
    bus(idx, 1'b1, wd, 4'hF, -1, x);
  endtask

  task automatic rdx(input logic [5:0] idx, input int exp);
    logic [7:0] x;
    bus(idx, 1'b0, 8'h00, 4'hF, exp, x);
  endtask

  task automatic rdv(input logic [5:0] idx, output logic [7:0] x);
    bus(idx, 1'b0, 8'h00, 4'hF, -1, x);
  endtask

  task automatic rd16(output logic [15:0] x);
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] lo2;
    rdv(IDX_COUNT_LOW, lo);
    rdv(IDX_COUNT_HIGH, hi);
    rdv(IDX_COUNT_LOW, lo2);
    if (lo2 < lo) begin
      rdv(IDX_COUNT_LOW, lo);
      rdv(IDX_COUNT_HIGH, hi);
    end
    x = {hi, lo};
  endtask

  always @(posedge clk_in) begin
    if (read_in && waitrequest_out === 1'b0 && expq.size() > 0) begin
      int e;
      e = expq.pop_front();
      if (e >= 0) check(readdata_out, 32'(e));
    end
  end

  initial begin
    #400000;
    fails++;
    report_and_stop;
  end

  initial begin
    srst_in = 1'b1;
    other_reset_in = 1'b0;
    vector_ack_in = 1'b0;
    address_in = '0;
    read_in = 1'b0;
    write_in = 1'b0;
    writedata_in = '0;
    byteenable_in = 4'h0;
    void'($urandom(48));
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rdx(IDX_TIMER_CONTROL, 'h00);
    rdx(IDX_CPU_STATUS, 'h10);
    rdx(IDX_INT_STATUS_EN, 'h00);
    rdx(IDX_EVENT_STATUS, 'h00);
    rdx(IDX_EVENT_MASK, 'h00);
    rdx(6'h3F, 'h00);
    // A write missing the low byte lane must be dropped
    bus(IDX_TIMER_CONTROL, 1'b1, 8'h40, 4'hE, -1, d);
    rdx(IDX_TIMER_CONTROL, 'h00);
    v = 16'($urandom);
    wr(IDX_CPU_STATUS, 8'h10);
    wr(IDX_COUNT_LOW, v[7:0]);
    wr(IDX_COUNT_HIGH, v[15:8]);
    wr(IDX_CPU_STATUS, 8'h00);
    wr(IDX_TIMER_CONTROL, 8'h40);
    @(posedge clk_in);
    other_reset_in <= 1'b1;
    @(posedge clk_in);
    other_reset_in <= 1'b0;
    rd16(r);
    check(r, v);
    rdx(IDX_TIMER_CONTROL, 'h00);
    rdx(IDX_CPU_STATUS, 'h10);
    // Every ratio, falling edge on even steps and rising on odd; a leftover edge tests that count writes clear the prescaler
    for (int c = 0; c <= 8; c++) begin
      code = (c < 8) ? 4'(c) : 4'(8 | ($urandom & 7));
      wr(IDX_COUNT_LOW, 8'h00);
      wr(IDX_COUNT_HIGH, 8'h00);
      wr(IDX_TIMER_CONTROL, {1'b0, c[0], 1'b0, code, 1'b0});
      tps_pin_model_i.pulses((2 << c) - 1);
      rdx(IDX_COUNT_LOW, 1);
      tps_pin_model_i.pulses(1);
      rdx(IDX_COUNT_LOW, 2);
      tps_pin_model_i.pulses(1);
    end
    // Reads are 43 clocks apart, so the exact count depends on phase;
    // the prescaler is cleared after each ratio change so no stray count lands
    wr(IDX_TIMER_CONTROL, 8'h20);
    wr(IDX_COUNT_HIGH, 8'h00);
    rdv(IDX_COUNT_LOW, a);
    repeat (40) @(posedge clk_in);
    rdv(IDX_COUNT_LOW, b);
    check(32'((8'(b - a)) inside {[10:11]}), 1);
    wr(IDX_TIMER_CONTROL, 8'h22);
    wr(IDX_COUNT_HIGH, 8'h00);
    rdv(IDX_COUNT_LOW, a);
    repeat (40) @(posedge clk_in);
    rdv(IDX_COUNT_LOW, b);
    check(32'((8'(b - a)) inside {[5:6]}), 1);
    wr(IDX_CPU_STATUS, 8'h10);
    wr(IDX_TIMER_CONTROL, 8'h40);
    wr(IDX_COUNT_LOW, 8'hFE);
    wr(IDX_COUNT_HIGH, 8'hFF);
    wr(IDX_CPU_STATUS, 8'h00);
    @(posedge clk_in);
    check(32'(global_irq_disable_out), 0);
    wr(IDX_INT_STATUS_EN, 8'h02);
    tps_pin_model_i.pulses(1);
    rdx(IDX_INT_STATUS_EN, 'h02);
    tps_pin_model_i.pulses(1);
    rdx(IDX_INT_STATUS_EN, 'h22);
    rdx(IDX_COUNT_LOW, 'h00);
    rdx(IDX_COUNT_HIGH, 'h00);
    rdx(IDX_EVENT_STATUS, 'h03);
    check(32'(overflow_request_out), 1);
    check(32'(irq_out), 0);
    wr(IDX_EVENT_MASK, 8'h01);
    repeat (2) @(posedge clk_in);
    check(32'(irq_out), 1);
    @(posedge clk_in);
    vector_ack_in <= 1'b1;
    @(posedge clk_in);
    vector_ack_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check(32'(overflow_request_out), 0);
    rdx(IDX_INT_STATUS_EN, 'h02);
    wr(IDX_EVENT_STATUS, 8'h03);
    repeat (2) @(posedge clk_in);
    check(32'(irq_out), 0);
    rdx(IDX_EVENT_STATUS, 'h00);
    report_and_stop;
  end
endmodule
